// ==== hdl/psor_regs.sv ====
// Purpose: Strap capture, overrides and wake routing registers of the transceiver
// Assumes: Requests come from the indirect access engine on the same clock
// Notes:   Read data returns one cycle after the request
//
// Summary of operation
// - Link-up time resets 100, gated by forced-100
// - Led override write updates led status
// - Led override bit always reads zero
// - Led status from strap, then override writes
// - Clock enable override, reset from strap
// - Strap status shows led and clock straps
// - Strap status low bits give address straps
// - Bit 10 enables wake on interrupt pin
// - Bit 8 enables wake on led pin
// - Bit 7 forces power-down, reset from mode
// - Pin select: wake, other, both, reserved
`timescale 1ns/1ps
module psor_regs (
    input  wire logic                  clk,            // 200 MHz clock
    input  wire logic                  rst,            // Synchronous reset, high
    input  wire psor_pkg::psor_strap_s strap_pins,     // Raw strap pins
    input  wire logic                  req_valid,      // Register access strobe
    input  wire psor_pkg::psor_req_s   req,            // Access details
    input  wire logic [15:0]           basic_ctrl,     // Basic control register value
    input  wire logic [1:0]            wake_sel,       // Wake output select field
    input  wire logic                  int_raw,        // Interrupt request, active high
    input  wire logic                  wake_raw,       // Wake event, active high
    input  wire logic                  first_led_pin_raw,       // Led one drive
    output logic                       rd_valid,       // Read data valid pulse
    output logic [15:0]                rd_data,        // Read data
    output logic                       led_single,     // Led style in force
    output logic                       ref_clk_en,     // Reference clock output on
    output logic                       chip_pwrdn,     // Chip power-down in force
    output logic [4:0]                 phy_addr,       // Management address
    output logic                       first_led_pin,  // Led one / wake pin level
    output logic                       int_pin_n       // Interrupt / wake pin, active low
);
    psor_pkg::psor_strap_s strap;        // Latched straps
    logic                  capture;      // Strap capture pulse
    logic                  load_dflt;    // Strap defaults load, capture plus one
    logic [2:0]            linkup_time;  // Link-up time field
    logic [4:0]            linkup_rsv;   // Writable reserved field
    logic                  led_stat;     // Led style status
    logic                  clk_en;       // Clock output override
    logic                  cc_rsv2;      // Writable reserved bit 2
    logic                  cc_rsv0;      // Writable reserved bit 0
    logic                  wake_two_en;  // Wake on interrupt pin
    logic                  wake_one_en;  // Wake on led pin
    logic                  pwrdn;        // Power-down override

    psor_strap_latch u_latch (
        .clk     (clk),
        .rst     (rst),
        .pins    (strap_pins),
        .strap   (strap),
        .capture (capture)
    );

    // Address decode
    wire hit_linkup = req.dev == psor_pkg::DEV_PMA && req.addr == psor_pkg::REG_GIG_LINKUP;
    wire in_vendor  = req.dev == psor_pkg::DEV_VENDOR;
    wire hit_common = in_vendor && req.addr == psor_pkg::REG_COMMON;
    wire hit_strap  = in_vendor && req.addr == psor_pkg::REG_STRAP_STAT;
    wire hit_ovr    = in_vendor && req.addr == psor_pkg::REG_OP_OVR;
    wire linkup_open = basic_ctrl == psor_pkg::BASIC_FORCED_100;
    wire wr = req_valid & req.wr;

    // Read views; unused and reserved read-only bits return zero
    wire [15:0] v_linkup = {7'h00, linkup_rsv, linkup_open ? linkup_time : 3'h0, 1'b0};
    wire [15:0] v_common = {11'h000, 1'b0, led_stat, cc_rsv2, clk_en, cc_rsv0};
    wire [15:0] v_strap  = {8'h00, strap.led_style, 1'b0, strap.clk_out, 2'h0,
                            strap.phy_addr};
    wire [15:0] v_ovr    = {5'h00, wake_two_en, 1'b0, wake_one_en, pwrdn, 7'h00};
    wire [15:0] next_rd  = hit_linkup ? v_linkup :
                           hit_common ? v_common :
                           hit_strap  ? v_strap  :
                           hit_ovr    ? v_ovr    : 16'h0000;

    // Pin routing, shared select encoding
    wire sel_wake  = wake_sel == 2'(psor_pkg::PSOR_SEL_WAKE_ONLY) ||
                     wake_sel == 2'(psor_pkg::PSOR_SEL_BOTH);
    wire sel_other = wake_sel == 2'(psor_pkg::PSOR_SEL_OTHER_ONLY) ||
                     wake_sel == 2'(psor_pkg::PSOR_SEL_BOTH);
    wire wake_on_int = sel_wake & wake_two_en & wake_raw;
    wire wake_on_led = sel_wake & wake_one_en & wake_raw;
    // Both-mode merges functions; pin is active low for the merged int
    wire next_int_n  = ~((sel_other & int_raw) | wake_on_int);
    wire next_first_led_pin   = (sel_other & first_led_pin_raw) | wake_on_led;

    // Defaults load one cycle after capture; strap only holds the new pins then
    always_ff @(posedge clk) begin
        if (rst) begin
            load_dflt <= 1'b0;
        end else begin
            load_dflt <= capture;
        end
    end

    // Link-up time register
    always_ff @(posedge clk) begin
        if (rst) begin
            linkup_time <= psor_pkg::LINKUP_RST;
            linkup_rsv  <= psor_pkg::LINKUP_RSV_RST;
        end else if (wr && hit_linkup) begin
            linkup_rsv <= req.data[psor_pkg::LINKUP_RSV_MSB:psor_pkg::LINKUP_RSV_LSB];
            if (linkup_open) begin
                linkup_time <= req.data[psor_pkg::LINKUP_MSB:psor_pkg::LINKUP_LSB];
            end
        end
    end

    // Common control; strap defaults loaded one cycle after capture
    always_ff @(posedge clk) begin
        if (rst) begin
            led_stat <= 1'b0;
            clk_en   <= 1'b0;
            cc_rsv2  <= 1'b0;
            cc_rsv0  <= 1'b0;
        end else if (load_dflt) begin
            led_stat <= strap.led_style;
            clk_en   <= strap.clk_out;
        end else if (wr && hit_common) begin
            led_stat <= req.data[psor_pkg::CC_LED_OVR];
            clk_en   <= req.data[psor_pkg::CC_CLK_EN];
            cc_rsv2  <= req.data[2];
            cc_rsv0  <= req.data[0];
        end
    end

    // Operation override register
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_two_en <= 1'b0;
            wake_one_en <= 1'b0;
            pwrdn       <= 1'b0;
        end else if (load_dflt) begin
            pwrdn <= strap.op_mode == psor_pkg::MODE_PWRDN;
        end else if (wr && hit_ovr) begin
            wake_two_en <= req.data[psor_pkg::OVR_WAKE_TWO];
            wake_one_en <= req.data[psor_pkg::OVR_WAKE_ONE];
            pwrdn       <= req.data[psor_pkg::OVR_PWRDN];
        end
    end

    // Registered outputs; reads answer one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_valid      <= 1'b0;
            rd_data       <= 16'h0000;
            led_single    <= 1'b0;
            ref_clk_en    <= 1'b0;
            chip_pwrdn    <= 1'b0;
            phy_addr      <= 5'h00;
            first_led_pin <= 1'b0;
            int_pin_n     <= 1'b1;
        end else begin
            rd_valid      <= req_valid & ~req.wr;
            rd_data       <= next_rd;
            led_single    <= led_stat;
            ref_clk_en    <= clk_en;
            chip_pwrdn    <= pwrdn;
            phy_addr      <= {2'b00, strap.phy_addr};
            first_led_pin <= next_first_led_pin;
            int_pin_n     <= next_int_n;
        end
    end

    // Checks
    sequence s_led_write;
        req_valid && req.wr && hit_common && !load_dflt;
    endsequence

    a_led_status: assert property (@(posedge clk) disable iff (rst)
        s_led_write |=> led_stat == $past(req.data[psor_pkg::CC_LED_OVR]))
        else $error("led status not updated by override write");
    a_led_wo_read: assert property (@(posedge clk) disable iff (rst)
        rd_valid |-> !(rd_data[psor_pkg::CC_LED_OVR] && $past(hit_common)))
        else $error("led override bit read back nonzero");
    a_linkup_gate: assert property (@(posedge clk) disable iff (rst)
        (wr && hit_linkup && !linkup_open) |=> $stable(linkup_time))
        else $error("link-up time written while locked");
    a_strap_hold: assert property (@(posedge clk) disable iff (rst)
        !capture |=> $stable(strap))
        else $error("strap copy changed after capture");
    a_addr_upper: assert property (@(posedge clk) disable iff (rst)
        phy_addr[4:3] == 2'b00)
        else $error("address upper bits not zero");
    a_strap_view: assert property (@(posedge clk) disable iff (rst)
        (req_valid && !req.wr && hit_strap) |=> rd_data[psor_pkg::SS_LED] == strap.led_style
        && rd_data[psor_pkg::SS_CLK] == strap.clk_out)
        else $error("strap status read wrong");
    a_pwrdn_out: assert property (@(posedge clk) disable iff (rst)
        pwrdn |=> chip_pwrdn)
        else $error("power-down not driven");
    a_wake_gate: assert property (@(posedge clk) disable iff (rst)
        (!wake_one_en && !sel_other) |=> !first_led_pin)
        else $error("led pin driven with wake disabled");
    a_int_wake: assert property (@(posedge clk) disable iff (rst)
        (wake_two_en && wake_raw && wake_sel == 2'b00) |=> !int_pin_n)
        else $error("wake not routed to interrupt pin");

    // Default load and override write steps
    sequence s_dflt_load;
        load_dflt;
    endsequence
    sequence s_ovr_write;
        wr && hit_ovr && !load_dflt;
    endsequence

    a_led_default: assert property (@(posedge clk) disable iff (rst)
        s_dflt_load |=> led_stat == $past(strap.led_style) && clk_en == $past(strap.clk_out))
        else $error("strap defaults not loaded");
    a_pwrdn_default: assert property (@(posedge clk) disable iff (rst)
        s_dflt_load |=> pwrdn == ($past(strap.op_mode) == psor_pkg::MODE_PWRDN))
        else $error("power-down default not loaded");
    a_clk_write: assert property (@(posedge clk) disable iff (rst)
        s_led_write |=> clk_en == $past(req.data[psor_pkg::CC_CLK_EN]))
        else $error("clock enable override not written");
    a_wake_en_write: assert property (@(posedge clk) disable iff (rst)
        s_ovr_write |=> wake_two_en == $past(req.data[psor_pkg::OVR_WAKE_TWO])
        && wake_one_en == $past(req.data[psor_pkg::OVR_WAKE_ONE]))
        else $error("wake enables not written");
    a_linkup_write: assert property (@(posedge clk) disable iff (rst)
        (wr && hit_linkup && linkup_open) |=> linkup_time == $past(req.data[psor_pkg::LINKUP_MSB:psor_pkg::LINKUP_LSB]))
        else $error("link-up time not written while open");
endmodule

// ==== include/psor_pkg.sv ====
// Purpose: Shared constants and carriers for the strap and override register bank
// Assumes: 16-bit extended registers reached through an indirect access engine
// Notes:   Offsets are the register numbers inside their extended device group
package psor_pkg;

    // Extended device groups
    localparam logic [4:0]  DEV_PMA        = 5'h01;    // Group holding link-up time
    localparam logic [4:0]  DEV_VENDOR     = 5'h02;    // Group holding strap registers

    // Register numbers
    localparam logic [15:0] REG_GIG_LINKUP = 16'h005a; // Link-up time control
    localparam logic [15:0] REG_COMMON     = 16'h0000; // Common control
    localparam logic [15:0] REG_STRAP_STAT = 16'h0001; // Strap status
    localparam logic [15:0] REG_OP_OVR     = 16'h0002; // Operation strap override

    // Basic control value that unlocks the link-up time field
    localparam logic [15:0] BASIC_FORCED_100 = 16'h2100;

    // Field positions
    localparam int LINKUP_LSB     = 1;   // Link-up time field low bit
    localparam int LINKUP_MSB     = 3;   // Link-up time field high bit
    localparam int LINKUP_RSV_LSB = 4;   // Writable reserved field low bit
    localparam int LINKUP_RSV_MSB = 8;   // Writable reserved field high bit
    localparam int CC_LED_OVR     = 4;   // Led style override, write-only
    localparam int CC_LED_STAT    = 3;   // Led style status
    localparam int CC_CLK_EN      = 1;   // Reference clock output enable
    localparam int SS_LED         = 7;   // Led style strap copy
    localparam int SS_CLK         = 5;   // Reference clock strap copy
    localparam int OVR_WAKE_TWO   = 10;  // Wake enable on interrupt pin
    localparam int OVR_WAKE_ONE   = 8;   // Wake enable on led pin
    localparam int OVR_PWRDN      = 7;   // Chip power-down override

    // Reset values
    localparam logic [2:0]  LINKUP_RST     = 3'h4;  // Binary 100
    localparam logic [4:0]  LINKUP_RSV_RST = 5'h10; // Reserved writable default
    localparam logic [3:0]  MODE_PWRDN     = 4'h7;  // Mode strap code for power-down

    // Shared pin select encoding
    typedef enum logic [1:0] {
        PSOR_SEL_WAKE_ONLY,
        PSOR_SEL_OTHER_ONLY,
        PSOR_SEL_BOTH,
        PSOR_SEL_RSVD
    } psor_sel_e;

    // Latched strap values
    typedef struct packed {
        logic       led_style;  // 1 = single-led
        logic       clk_out;    // 1 = reference clock on
        logic [2:0] phy_addr;   // Low address bits
        logic [3:0] op_mode;    // Operating mode straps
    } psor_strap_s;

    // Register access request
    typedef struct packed {
        logic        wr;        // Write strobe
        logic [4:0]  dev;       // Device group
        logic [15:0] addr;      // Register number
        logic [15:0] data;      // Write data
    } psor_req_s;

endpackage

// ==== hdl/psor_strap_latch.sv ====
// Purpose: Synchronise strap pins and capture them once at reset release
// Assumes: Pins are asynchronous; rst is synchronous active high
// Notes:   Capture fires on the first cycle after rst falls
`timescale 1ns/1ps
module psor_strap_latch (
    input  wire logic                   clk,      // 200 MHz clock
    input  wire logic                   rst,      // Synchronous reset
    input  wire psor_pkg::psor_strap_s  pins,     // Raw strap pins
    output psor_pkg::psor_strap_s       strap,    // Held strap values
    output logic                        capture   // One-cycle capture pulse
);
    psor_pkg::psor_strap_s sync_a;  // First stage, read only by second
    psor_pkg::psor_strap_s sync_b;  // Second stage
    logic                  in_rst;  // Reset seen last cycle

    // Two-stage synchroniser
    always_ff @(posedge clk) begin
        sync_a <= pins;
        sync_b <= sync_a;
    end

    // Falling edge of reset marks capture
    assign capture = in_rst & ~rst;

    // Latch once, hold until next reset
    always_ff @(posedge clk) begin
        in_rst <= rst;
        if (rst) begin
            strap <= '0;
        end else if (capture) begin
            strap <= sync_b;
        end
    end
endmodule

// ==== sim/psor_host.sv ====
// Purpose: Behavioural management host issuing decoded register accesses
// Assumes: Tasks are entered just after a rising edge
// Notes:   Idle request fields show the inverse of the last access
`timescale 1ns/1ps
module psor_host (
    input  wire logic           clk,       // Bench clock
    input  wire logic           rd_valid,  // Read answer strobe
    input  wire logic [15:0]    rd_data,   // Read answer data
    output logic                req_valid, // Access strobe
    output psor_pkg::psor_req_s req        // Access details
);
    // Idle at time zero
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end

    // One access held over its taking edge; reads sample the answer once, 1 ns after that edge
    task automatic access(input logic wr, input logic [4:0] dev, input logic [15:0] addr,
                          input logic [15:0] data, output logic [15:0] q, output logic ok);
        req_valid = 1'b1;
        req       = '{wr, dev, addr, data};
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        req       = ~req;  // Released fields must not look valid
        ok        = wr;
        q         = 16'h0000;
        // Answer stands only in the cycle after the taking edge
        if (!wr && rd_valid === 1'b1) begin
            ok = 1'b1;
            q  = rd_data;
        end
        // Idle edge so a following call never retoggles the strobe at once
        @(posedge clk);
        #1;
    endtask
endmodule

// ==== sim/phy_strap_override_regs_bench.sv ====
// Purpose: Self-checking bench for the strap and override register bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Straps are changed after reset to show they stay latched
`timescale 1ns/1ps
module phy_strap_override_regs_bench;
    logic                  clk = 1'b0;     // 200 MHz clock
    logic                  rst = 1'b1;     // Synchronous reset
    psor_pkg::psor_strap_s pins = '0;      // Strap pins
    logic                  req_valid;      // Access strobe
    psor_pkg::psor_req_s   req;            // Access details
    logic [15:0]           basic = '0;     // Basic control value
    logic [1:0]            sel = '0;       // Wake select field
    logic [2:0]            raw = '0;       // {int, wake, first_led_pin}
    logic                  rd_valid;       // Read strobe
    logic [15:0]           rd_data;        // Read data
    logic                  led_single, ref_clk_en, chip_pwrdn, first_led_pin, int_pin_n; // Levels
    logic [4:0]            phy_addr;       // Management address
    int                    mismatches = 0; // Failed compares
    int                    n_checks = 0;   // All compares

    always #2.5 clk = ~clk;

    psor_host i_host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .req_valid(req_valid), .req(req));

    psor_regs i_dut (.clk(clk), .rst(rst), .strap_pins(pins), .req_valid(req_valid), .req(req),
        .basic_ctrl(basic), .wake_sel(sel), .int_raw(raw[2]), .wake_raw(raw[1]), .first_led_pin_raw(raw[0]),
        .rd_valid(rd_valid), .rd_data(rd_data), .led_single(led_single), .ref_clk_en(ref_clk_en),
        .chip_pwrdn(chip_pwrdn), .phy_addr(phy_addr), .first_led_pin(first_led_pin), .int_pin_n(int_pin_n));

    // Verdict, reached from the main flow or a missing read answer
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Read and compare; a missing answer ends the run
    task automatic rdc(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] exp);
        logic [15:0] q;
        logic        ok;
        i_host.access(1'b0, dev, addr, 16'h0000, q, ok);
        if (!ok) begin
            mismatches++;
            end_of_test();
        end else begin
            check(q, exp);
        end
    endtask

    task automatic wr(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] data);
        logic [15:0] q;
        logic        ok;
        i_host.access(1'b1, dev, addr, data, q, ok);
    endtask

    task automatic do_reset(input psor_pkg::psor_strap_s p);
        rst  = 1'b1;
        pins = p;
        tick(4);
        rst = 1'b0;
        tick(4);
    endtask

    // Expected {first_led_pin, int_pin_n} for a select and raw inputs
    // en[0] gates wake on the led pin, en[1] on the interrupt pin
    function automatic logic [1:0] pin_exp(input logic [1:0] s, input logic [1:0] en, input logic [2:0] r);
        logic w1;
        logic w2;
        w1 = en[0] & r[1];
        w2 = en[1] & r[1];
        case (s)
            2'b00:   return {w1, ~w2};
            2'b01:   return {r[0], ~r[2]};
            2'b10:   return {r[0] | w1, ~(r[2] | w2)};
            default: return 2'b01; // Reserved drives nothing
        endcase
    endfunction

    localparam logic [4:0] DV = psor_pkg::DEV_VENDOR;

    initial begin
        do_reset('{1'b1, 1'b0, 3'h5, psor_pkg::MODE_PWRDN});
        pins = '0; // Later pin activity must be ignored
        tick(3);
        rdc(DV, psor_pkg::REG_STRAP_STAT, 16'h0085);
        check({11'h0, phy_addr}, 16'h0005);
        check({13'h0, led_single, ref_clk_en, chip_pwrdn}, 16'h0005);
        rdc(DV, psor_pkg::REG_COMMON, 16'h0008);
        rdc(DV, psor_pkg::REG_OP_OVR, 16'h0080);
        wr(DV, psor_pkg::REG_COMMON, 16'h0002);
        rdc(DV, psor_pkg::REG_COMMON, 16'h0002);
        wr(DV, psor_pkg::REG_COMMON, 16'h0015);
        rdc(DV, psor_pkg::REG_COMMON, 16'h000d);
        tick(2);
        check({14'h0, led_single, ref_clk_en}, 16'h0002);
        rdc(DV, psor_pkg::REG_STRAP_STAT, 16'h0085);
        wr(DV, psor_pkg::REG_OP_OVR, 16'h0500);
        rdc(DV, psor_pkg::REG_OP_OVR, 16'h0500);
        tick(2);
        check({15'h0, chip_pwrdn}, 16'h0000);
        for (int e = 3; e >= 0; e--) begin
            wr(DV, psor_pkg::REG_OP_OVR, {5'h00, e[1], 1'b0, e[0], 8'h00});
            for (int k = 0; k < 32; k++) begin
                sel = k[4:3];
                raw = k[2:0];
                tick(3);
                check({14'h0, first_led_pin, int_pin_n}, {14'h0, pin_exp(sel, e[1:0], raw)});
            end
        end
        rdc(psor_pkg::DEV_PMA, psor_pkg::REG_GIG_LINKUP, 16'h0100);
        wr(psor_pkg::DEV_PMA, psor_pkg::REG_GIG_LINKUP, 16'h010e);
        rdc(psor_pkg::DEV_PMA, psor_pkg::REG_GIG_LINKUP, 16'h0100);
        basic = psor_pkg::BASIC_FORCED_100;
        rdc(psor_pkg::DEV_PMA, psor_pkg::REG_GIG_LINKUP, 16'h0108);
        wr(psor_pkg::DEV_PMA, psor_pkg::REG_GIG_LINKUP, 16'h0106);
        rdc(psor_pkg::DEV_PMA, psor_pkg::REG_GIG_LINKUP, 16'h0106);
        basic = 16'h2101;
        rdc(psor_pkg::DEV_PMA, psor_pkg::REG_GIG_LINKUP, 16'h0100);
        wr(DV, 16'h0003, 16'hffff);
        rdc(DV, 16'h0003, 16'h0000);
        rdc(psor_pkg::DEV_PMA, psor_pkg::REG_COMMON, 16'h0000);
        do_reset('{1'b0, 1'b1, 3'h2, 4'h0});
        tick(3);
        rdc(DV, psor_pkg::REG_STRAP_STAT, 16'h0022);
        rdc(DV, psor_pkg::REG_COMMON, 16'h0002);
        rdc(DV, psor_pkg::REG_OP_OVR, 16'h0000);
        basic = psor_pkg::BASIC_FORCED_100;
        rdc(psor_pkg::DEV_PMA, psor_pkg::REG_GIG_LINKUP, 16'h0108);
        end_of_test();
    end
endmodule
